// ==== src/vbuf_ctrl.sv ====
// Host-side controller driving a dual-port video buffer through its strobe pins
//
// Notes on behaviour
// RL1: Device offers 64K x 4 random port and 256 x 4 serial port.
// RL2: Write cycles may mask individual data bits; masked bits keep old value.
// RL3: Random and serial ports run independently except during row transfer.
// RL4: Serial keeps old data during transfer; switches at transfer clocking edge.
// RL5: Controller cycles all 256 rows within every 4 ms.
// RL6: Column strobe before row strobe refreshes from device internal counter.
// RL7: Hidden refresh keeps read data driven under column strobe control.
// RL8: Transferring a row into the data register also refreshes it.
// RL9: Device latches address and write data; read data is unlatched.
// RL10: Rising transfer/output-enable edge commits row transfer and serial start.
// RL11: Transfer cycle has random cycle timing and starts at row strobe.
// RL12: Transfer row address picks row; column address picks serial start.
// RL13: Transfers accepted whether serial port shifts or idles.
// RL14: Each serial clock pulse presents next 4 bits, gated by serial enable.
// RL15: Serial outputs of several devices may share lines when one is enabled.
// RL16: Write mask shares data pins; controller drives it at row strobe.
// RL17: Array is 256 rows by 1024 columns, 16-bit cell address.
// RL18: Row address latched by row strobe, then column by column strobe.
// RL19: Controller holds each address stable by its latching strobe edge.
// RL20: Row strobe senses and restores the whole 1024-cell row.
// RL21: Column strobe selects column decoder and data buffers.
// RL22: Read, early write, late write, RMW, row-only refresh, page cycles.
// RL23: Low transfer pin at row strobe fall selects transfer cycle.
// RL24: Mask bits low at row strobe fall inhibit writing those bits.
// RL25: Column strobe low at row fall refreshes internal counter row.
// RL26: Device internal refresh counter is 8 bits and wraps.
`timescale 1ns/1ps
module vbuf_ctrl #(
  parameter int unsigned REFRESH_PERIOD = vbuf_ctrl_pkg::REFRESH_CYCLES
) (
  input  wire logic                                    i_clk,
  input  wire logic                                    i_rst_n,
  input  wire logic                                    i_ce,
  input  wire logic                                    i_req_valid,
  input  wire vbuf_ctrl_pkg::req_t                     i_req,
  output logic                                         o_req_ready,
  output logic                                         o_rdata_valid,
  output logic [vbuf_ctrl_pkg::DATA_W-1:0]             o_rdata,
  input  wire logic [vbuf_ctrl_pkg::DATA_W-1:0]        i_mask_or_data_io,
  output vbuf_ctrl_pkg::pins_t                         o_pins,
  input  wire logic                                    i_serial_step,
  input  wire logic                                    i_serial_enable,
  output logic                                         o_serial_shift_clock,
  output logic                                         o_serial_out_enable_n
);
  import vbuf_ctrl_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ROW    = 3'b001,
    ST_RAS    = 3'b010,
    ST_COL    = 3'b011,
    ST_CAS    = 3'b100,
    ST_END    = 3'b101,
    ST_PRE    = 3'b110
  } state_t;

  state_t             state;
  state_t             next_state;
  req_t               cur;
  req_t               next_cur;
  pins_t              next_pins;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic [DATA_W-1:0]  next_rdata;
  logic               next_rdata_valid;
  logic               next_shift;
  logic               refresh_due;
  logic               refresh_taken;
  logic [DATA_W-1:0]  io_agreed;
  logic [DATA_W-1:0]  next_io_agreed;
  logic [DATA_W-1:0]  io_s1;
  logic [DATA_W-1:0]  io_s2;
  logic [DATA_W-1:0]  io_s3;

  // Refresh pacing: one row each slot keeps all rows inside the window
  vbuf_refresh_timer #(
    .PERIOD  (REFRESH_PERIOD)
  ) u_refresh (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_taken (refresh_taken),
    .o_due   (refresh_due)
  ); // [RL5]

  // Refresh wins over user requests so a busy host cannot starve the array
  assign o_req_ready   = (state == ST_IDLE) && !refresh_due;
  assign refresh_taken = (state == ST_IDLE) && refresh_due;

  always_comb begin
    next_state       = state;
    next_cur         = cur;
    next_pins        = o_pins;
    next_timer       = (timer == '0) ? timer : timer - 1'b1;
    next_rdata       = o_rdata;
    next_rdata_valid = 1'b0;
    case (state)
      ST_IDLE: begin
        next_pins.mask_or_data_io_oe = '0;
        if (refresh_due) begin
          next_cur          = '0;
          next_cur.cmd      = CMD_REFRESH;
          next_cur.cbr      = 1'b1;
          next_state        = ST_ROW;
        end else if (i_req_valid) begin
          next_cur   = i_req;
          next_state = ST_ROW;
        end
      end
      ST_ROW: begin
        // Address and mode pins settle a full cycle before the row strobe
        next_pins.muxed_address               = cur.row; // [RL18] [RL19] [RL12]
        next_pins.transfer_or_output_enable_n = (cur.cmd != CMD_TRANSFER); // [RL23]
        next_pins.bitmask_or_write_enable_n   = !(cur.cmd == CMD_WRITE && cur.use_mask);
        next_pins.mask_or_data_io_out         = cur.mask; // [RL16] [RL24]
        next_pins.mask_or_data_io_oe          = (cur.cmd == CMD_WRITE && cur.use_mask) ? ALL_BITS : '0;
        // Counter refresh: column strobe goes low before the row strobe
        next_pins.cas_n = !(cur.cmd == CMD_REFRESH && cur.cbr); // [RL6] [RL25]
        next_timer = TIMER_W'(PHASE_CYC);
        next_state = ST_RAS;
      end
      ST_RAS: begin
        next_pins.ras_n = 1'b0; // [RL11] [RL20]
        next_timer      = TIMER_W'(PHASE_CYC);
        next_state      = ST_COL;
      end
      ST_COL: begin
        if (timer == '0) begin
          next_pins.mask_or_data_io_oe        = '0;
          next_pins.bitmask_or_write_enable_n = 1'b1;
          next_pins.muxed_address             = cur.col; // [RL18] [RL12]
          if (cur.cmd == CMD_WRITE) begin
            // Early write: enable low and data on pins before column strobe
            next_pins.bitmask_or_write_enable_n = 1'b0;
            next_pins.mask_or_data_io_out       = cur.wdata;
            next_pins.mask_or_data_io_oe        = ALL_BITS; // [RL2]
          end
          if (cur.cmd == CMD_READ) begin
            next_pins.transfer_or_output_enable_n = 1'b0;
          end
          next_timer = TIMER_W'(PHASE_CYC);
          next_state = (cur.cmd == CMD_REFRESH) ? ST_END : ST_CAS;
        end
      end
      ST_CAS: begin
        if (timer == '0) begin
          next_pins.cas_n = 1'b0; // [RL21]
          next_timer      = TIMER_W'(ACCESS_CYC);
          next_state      = ST_END;
        end
      end
      ST_END: begin
        if (timer == '0) begin
          if (cur.cmd == CMD_READ) begin
            next_rdata       = io_agreed;
            next_rdata_valid = 1'b1;
          end
          // Rising transfer pin commits the row and the serial start
          next_pins.transfer_or_output_enable_n = 1'b1; // [RL10] [RL4] [RL8]
          next_pins.ras_n                       = 1'b1;
          next_pins.cas_n                       = 1'b1;
          next_pins.bitmask_or_write_enable_n   = 1'b1;
          next_pins.mask_or_data_io_oe          = '0;
          next_timer                            = TIMER_W'(RAS_PRE_CYC);
          next_state                            = ST_PRE;
        end
      end
      ST_PRE: begin
        if (timer == '0) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Serial side runs on its own, untouched by random port cycles
  always_comb begin
    next_shift = i_serial_step && !o_serial_shift_clock; // [RL3] [RL13] [RL14]
  end

  // Data pins come from the device: take a value only once the two late stages agree
  always_comb begin
    next_io_agreed = (io_s2 == io_s3) ? io_s3 : io_agreed;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state                   <= ST_IDLE;
      cur                     <= '0;
      timer                   <= '0;
      o_rdata                 <= '0;
      o_rdata_valid           <= 1'b0;
      o_pins                  <= '{ras_n: 1'b1, cas_n: 1'b1, transfer_or_output_enable_n: 1'b1,
                                   bitmask_or_write_enable_n: 1'b1, default: '0};
      o_serial_shift_clock    <= 1'b0;
      o_serial_out_enable_n   <= 1'b1;
      io_s1                   <= '0;
      io_s2                   <= '0;
      io_s3                   <= '0;
      io_agreed               <= '0;
    end else if (i_ce) begin
      state                   <= next_state;
      cur                     <= next_cur;
      timer                   <= next_timer;
      o_rdata                 <= next_rdata;
      o_rdata_valid           <= next_rdata_valid;
      o_pins                  <= next_pins;
      o_serial_shift_clock    <= next_shift;
      // Only one device should be enabled onto shared serial lines
      o_serial_out_enable_n   <= !i_serial_enable; // [RL15]
      io_s1                   <= i_mask_or_data_io;
      io_s2                   <= io_s1;
      io_s3                   <= io_s2;
      io_agreed               <= next_io_agreed;
    end
  end
endmodule : vbuf_ctrl

// ==== src/vbuf_ctrl_pkg.sv ====
// Package: pin bundles, command codes and timing constants for the video buffer controller
package vbuf_ctrl_pkg;
  localparam int unsigned CLK_MHZ        = 25;
  localparam int unsigned REFRESH_MS     = 4;
  localparam int unsigned ROW_COUNT      = 256;
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned DATA_W         = 4;
  // Refresh period split evenly over all rows, rounded down so no row is late
  localparam int unsigned REFRESH_CYCLES = (REFRESH_MS * 1000 * CLK_MHZ) / ROW_COUNT;
  localparam int unsigned REFRESH_CNT_W  = 16;
  // Strobe phase lengths in clock cycles (each at least one 40 ns cycle)
  localparam int unsigned RAS_PRE_NS     = 120;
  localparam int unsigned RAS_PRE_CYC    = (RAS_PRE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PHASE_CYC      = 2;
  localparam int unsigned ACCESS_NS      = 160;
  localparam int unsigned ACCESS_CYC     = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TIMER_W        = 4;
  localparam logic [3:0]  ALL_BITS       = 4'hF;

  typedef enum logic [1:0] {
    CMD_READ     = 2'b00,
    CMD_WRITE    = 2'b01,
    CMD_TRANSFER = 2'b10,
    CMD_REFRESH  = 2'b11
  } cmd_t;

  typedef struct packed {
    cmd_t              cmd;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] mask;    // 1 = write this bit
    logic              use_mask;
    logic              cbr;     // refresh by internal counter instead of row
  } req_t;

  typedef struct packed {
    logic              ras_n;
    logic              cas_n;
    logic              transfer_or_output_enable_n;
    logic              bitmask_or_write_enable_n;
    logic [ADDR_W-1:0] muxed_address;
    logic [DATA_W-1:0] mask_or_data_io_out;
    logic [DATA_W-1:0] mask_or_data_io_oe;
  } pins_t;
endpackage : vbuf_ctrl_pkg

// ==== src/vbuf_refresh_timer.sv ====
// Refresh pacing timer: raises a request every refresh slot, held until taken
`timescale 1ns/1ps
module vbuf_refresh_timer #(
  parameter int unsigned PERIOD = vbuf_ctrl_pkg::REFRESH_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  input  wire logic i_taken,
  output logic      o_due
);
  import vbuf_ctrl_pkg::*;
  logic [REFRESH_CNT_W-1:0] count;
  logic [REFRESH_CNT_W-1:0] next_count;
  logic                     next_due;

  always_comb begin
    next_count = count;
    next_due   = o_due;
    if (count == REFRESH_CNT_W'(PERIOD - 1)) begin
      next_count = '0;
      next_due   = 1'b1;
    end else begin
      next_count = count + 1'b1;
    end
    // A new slot arriving with the take keeps the request alive
    if (i_taken && !(count == REFRESH_CNT_W'(PERIOD - 1))) begin
      next_due = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= '0;
      o_due <= 1'b0;
    end else if (i_ce) begin
      count <= next_count;
      o_due <= next_due;
    end
  end
endmodule : vbuf_refresh_timer

// ==== sim/vbuf_ctrl_monitor.sv ====
// Checker: strobe phases, pin values and refresh pacing of the video buffer controller
`timescale 1ns/1ps
module vbuf_ctrl_monitor #(
  parameter int unsigned REFRESH_PERIOD = vbuf_ctrl_pkg::REFRESH_CYCLES
) (
  input wire logic                 i_clk,
  input wire logic                 i_rst_n,
  input wire logic                 i_ce,
  input wire logic                 i_req_valid,
  input wire vbuf_ctrl_pkg::req_t  i_req,
  input wire logic                 o_req_ready,
  input wire logic                 o_rdata_valid,
  input wire vbuf_ctrl_pkg::pins_t o_pins,
  input wire logic                 i_serial_step,
  input wire logic                 o_serial_shift_clock
);
  import vbuf_ctrl_pkg::*;
  req_t        last_req, next_last_req;
  logic [15:0] gap, next_gap;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  always_comb begin
    next_last_req = (i_ce && i_req_valid && o_req_ready) ? i_req : last_req;
    // Only a counter refresh lowers CAS while RAS is still high; frozen cycles do not count
    next_gap = (!o_pins.cas_n && o_pins.ras_n) ? 16'h0000 : (i_ce ? gap + 16'h0001 : gap);
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) {last_req, gap} <= '0;
    else {last_req, gap} <= {next_last_req, next_gap};
  end
  sequence s_row; $fell(o_pins.ras_n) && o_pins.cas_n; endsequence
  sequence s_col; $fell(o_pins.cas_n) && !o_pins.ras_n; endsequence
  property p_row; s_row |-> $stable(o_pins.muxed_address) && o_pins.muxed_address == last_req.row; endproperty
  a_row: assert property (p_row) else $error("row address wrong");
  property p_col; s_col |-> $stable(o_pins.muxed_address) && o_pins.muxed_address == last_req.col; endproperty
  a_col: assert property (p_col) else $error("column address wrong");
  property p_kind; s_row |-> o_pins.transfer_or_output_enable_n == (last_req.cmd != CMD_TRANSFER); endproperty
  a_kind: assert property (p_kind) else $error("cycle kind wrong");
  property p_mask; s_row |-> last_req.cmd != CMD_WRITE || (o_pins.bitmask_or_write_enable_n == !last_req.use_mask
    && (!last_req.use_mask || o_pins.mask_or_data_io_oe == ALL_BITS && o_pins.mask_or_data_io_out == last_req.mask));
  endproperty
  a_mask: assert property (p_mask) else $error("write mask phase wrong");
  property p_wr; s_col |-> last_req.cmd != CMD_WRITE
    || !o_pins.bitmask_or_write_enable_n && o_pins.mask_or_data_io_out == last_req.wdata; endproperty
  a_wr: assert property (p_wr) else $error("early write data wrong");
  property p_bus; !o_pins.cas_n && !o_pins.transfer_or_output_enable_n |-> o_pins.mask_or_data_io_oe == 4'h0; endproperty
  a_bus: assert property (p_bus) else $error("data pins driven while device drives");
  property p_ref; gap <= 16'(REFRESH_PERIOD + 40); endproperty
  a_ref: assert property (p_ref) else $error("refresh late");
  property p_sc; i_serial_step && !o_serial_shift_clock |=> o_serial_shift_clock ##1 !o_serial_shift_clock; endproperty
  a_sc: assert property (p_sc) else $error("shift clock pulse wrong");
  c_read: cover property (o_rdata_valid);
  c_xfer: cover property (s_row ##0 !o_pins.transfer_or_output_enable_n);
  c_mask: cover property (s_row ##0 !o_pins.bitmask_or_write_enable_n);
endmodule : vbuf_ctrl_monitor
bind vbuf_ctrl vbuf_ctrl_monitor #(.REFRESH_PERIOD(REFRESH_PERIOD)) u_monitor (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req_valid(i_req_valid), .i_req(i_req),
  .o_req_ready(o_req_ready), .o_rdata_valid(o_rdata_valid), .o_pins(o_pins), .i_serial_step(i_serial_step),
  .o_serial_shift_clock(o_serial_shift_clock));

// ==== sim/vbuf_device_model.sv ====
// Device model: dual-port video buffer reacting to its strobe pins
`timescale 1ns/1ps
module vbuf_device_model (
  input  wire logic       i_ras_n,
  input  wire logic       i_cas_n,
  input  wire logic       i_xfer_n,
  input  wire logic       i_we_n,
  input  wire logic [7:0] i_addr,
  input  wire logic [3:0] i_io,
  input  wire logic       i_sclk,
  input  wire logic       i_soe_n,
  output logic [3:0]      o_io_drv,
  output logic            o_io_en,
  output logic [3:0]      o_sdata
);
  logic [3:0] mem [65536];
  logic [3:0] sreg [256];
  logic [3:0] mask, word;
  logic [7:0] row, col, rcnt, spos;
  logic       xfer, cbr;
  initial begin
    foreach (mem[k]) mem[k] = 4'h0;
    foreach (sreg[k]) sreg[k] = 4'h0;
    {row, col, rcnt, spos, xfer, cbr, word} = '0;
  end
  always @(negedge i_ras_n) begin
    cbr  = !i_cas_n;
    row  = cbr ? rcnt : i_addr;
    xfer = !i_xfer_n && !cbr;
    mask = (!i_we_n && !cbr) ? i_io : 4'hF;
    if (cbr) rcnt = rcnt + 8'h01;
  end
  always @(negedge i_cas_n) begin
    if (!i_ras_n && !cbr) col = i_addr;
    if (!i_ras_n && !cbr && !i_we_n && !xfer) mem[{row, col}] = (mem[{row, col}] & ~mask) | (i_io & mask);
  end
  always @(posedge i_xfer_n) begin
    if (xfer) begin
      for (int k = 0; k < 256; k++) sreg[k] = mem[{row, 8'(k)}];
      spos = col;
      xfer = 1'b0;
    end
  end
  always @(posedge i_sclk) begin
    word = sreg[spos];
    spos = spos + 8'h01;
  end
  // Disabled outputs float: show the inverse so a stale value never matches
  assign o_sdata  = i_soe_n ? ~word : word;
  assign o_io_en  = !i_cas_n && !i_xfer_n && i_we_n && !xfer && !cbr;
  assign o_io_drv = mem[{row, col}];
endmodule : vbuf_device_model

// ==== sim/tb_top.sv ====
// Testbench: random traffic through the controller against a model of the buffer device
`timescale 1ns/1ps
module tb_top;
  import vbuf_ctrl_pkg::*;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_req_valid = 1'b0, i_serial_step = 1'b0, i_serial_enable = 1'b0;
  logic        i_ce = 1'b1;
  req_t        i_req = '0;
  pins_t       pins;
  logic        o_req_ready, o_rdata_valid, o_shift, o_soe_n, dev_en;
  logic [3:0]  o_rdata, io, dev_drv, sdata, last_io = 4'h0;
  logic [31:0] seed = 32'h5028_8f77;
  int          bad_count = 0, check_count = 0, cyc = 0, exp_mem [65536];
  int          ser_q [$];
  always #20 i_clk = ~i_clk;
  // Undriven bits show the inverse of their last level
  assign io = (pins.mask_or_data_io_oe & pins.mask_or_data_io_out)
            | (~pins.mask_or_data_io_oe & (dev_en ? dev_drv : ~last_io));
  always @(posedge i_clk) last_io <= io;
  vbuf_ctrl #(.REFRESH_PERIOD(20)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_rdata_valid(o_rdata_valid), .o_rdata(o_rdata),
    .i_mask_or_data_io(io), .o_pins(pins), .i_serial_step(i_serial_step), .i_serial_enable(i_serial_enable),
    .o_serial_shift_clock(o_shift), .o_serial_out_enable_n(o_soe_n));
  vbuf_device_model dev (.i_ras_n(pins.ras_n), .i_cas_n(pins.cas_n), .i_xfer_n(pins.transfer_or_output_enable_n),
    .i_we_n(pins.bitmask_or_write_enable_n), .i_addr(pins.muxed_address), .i_io(io), .i_sclk(o_shift),
    .i_soe_n(o_soe_n), .o_io_drv(dev_drv), .o_io_en(dev_en), .o_sdata(sdata));
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic request(input cmd_t cmd, input logic [7:0] row, col, input logic [3:0] wd, mk, input logic um);
    int         n = 0;
    logic [3:0] m;
    @(posedge i_clk);
    i_req_valid <= 1'b1;
    i_req       <= '{cmd, row, col, wd, mk, um, 1'b0};
    do @(posedge i_clk); while (o_req_ready !== 1'b1 && ++n < 300);
    check(32'(o_req_ready), 32'h0000_0001);
    i_req_valid <= 1'b0;
    m = um ? mk : 4'hF;
    if (cmd == CMD_WRITE) exp_mem[{row, col}] = (exp_mem[{row, col}] & ~int'(m)) | int'(wd & m);
    n = 0;
    // A transfer returns only once the row has been committed
    if (cmd == CMD_TRANSFER) do @(posedge i_clk); while (pins.transfer_or_output_enable_n !== 1'b0 && ++n < 40);
    if (cmd == CMD_TRANSFER) check(32'(pins.transfer_or_output_enable_n), 32'h0000_0000);
    if (cmd == CMD_TRANSFER) do @(posedge i_clk); while (pins.transfer_or_output_enable_n !== 1'b1 && ++n < 40);
    if (cmd == CMD_TRANSFER) check(32'(pins.transfer_or_output_enable_n), 32'h0000_0001);
    if (cmd == CMD_TRANSFER) ser_q.delete();
    if (cmd == CMD_TRANSFER) for (int k = 0; k < 256; k++) ser_q.push_back(exp_mem[{row, 8'(col + k)}]);
    if (cmd == CMD_READ) do @(posedge i_clk); while (o_rdata_valid !== 1'b1 && ++n < 40);
    if (cmd == CMD_READ) check(32'(o_rdata_valid), 32'h0000_0001);
    if (cmd == CMD_READ) check(32'(o_rdata), exp_mem[{row, col}]);
  endtask : request
  task automatic sstep();
    @(posedge i_clk);
    i_serial_step <= 1'b1;
    @(posedge i_clk);
    i_serial_step <= 1'b0;
    repeat (3) @(posedge i_clk);
    check(32'(sdata), ser_q.pop_front());
  endtask : sstep
  task report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    logic [31:0] r;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      r = rnd();
      request(CMD_WRITE, r[7:0], r[15:8], r[19:16], 4'h0, 1'b0);
      request(CMD_WRITE, r[7:0], r[15:8], r[23:20], r[27:24], 1'b1);
      request(CMD_READ, r[7:0], r[15:8], 4'h0, 4'h0, 1'b0);
    end
    // Frozen clock enable must also stop refresh pacing
    i_ce <= 1'b0;
    repeat (30) begin
      @(posedge i_clk);
      check(32'(pins.cas_n), 32'h0000_0001);
    end
    i_ce <= 1'b1;
    request(CMD_REFRESH, r[7:0], 8'h00, 4'h0, 4'h0, 1'b0);
    r = rnd();
    for (int k = 0; k < 8; k++) request(CMD_WRITE, r[7:0], 8'(k), 4'(k + 3), 4'h0, 1'b0);
    for (int k = 0; k < 4; k++) request(CMD_WRITE, 8'hFF, 8'(k + 254), 4'(k + 9), 4'h0, 1'b0);
    i_serial_enable <= 1'b1;
    request(CMD_TRANSFER, r[7:0], 8'h00, 4'h0, 4'h0, 1'b0);
    for (int k = 0; k < 6; k++) sstep();
    fork
      request(CMD_TRANSFER, 8'hFF, 8'hFE, 4'h0, 4'h0, 1'b0);
      repeat (2) sstep();
    join
    repeat (4) sstep();
    check(32'(o_soe_n), 32'h0000_0000);
    i_serial_enable <= 1'b0;
    repeat (3) @(posedge i_clk);
    check(32'(o_soe_n), 32'h0000_0001);
    report_and_stop();
  end
endmodule : tb_top
